// ==== src/adcps_pkg.sv ====
package adcps_pkg;
  // bus and data widths
  localparam int ADCPS_AW = 8;
  localparam int ADCPS_DW = 32;
  localparam int ADCPS_NCH = 14;
  localparam int ADCPS_RW = 10;
  // register byte offsets
  localparam logic [7:0] ADCPS_OFF_CTRL0 = 8'h00;
  localparam logic [7:0] ADCPS_OFF_CTRL1 = 8'h04;
  localparam logic [7:0] ADCPS_OFF_RES0 = 8'h40;
  localparam logic [7:0] ADCPS_OFF_RES13 = 8'h74;
  // scan_control_reg0 field positions
  localparam int ADCPS_C0_RUN = 15;
  localparam int ADCPS_C0_ACTIVE = 14;
  localparam int ADCPS_C0_SELMODE = 11;
  localparam int ADCPS_C0_POLL = 10;
  localparam logic [15:0] ADCPS_C0_WMASK = 16'hBFFF;
  // scan_control_reg1 field positions
  localparam int ADCPS_C1_FIRST_LSB = 0;
  localparam int ADCPS_C1_LAST_LSB = 4;
  localparam int ADCPS_C1_SEL_LSB = 8;
  // values after reset
  localparam logic [15:0] ADCPS_C0_RST = 16'h0000;
  localparam logic [15:0] ADCPS_C1_RST = 16'h0000;
  localparam logic [9:0] ADCPS_RES_RST = 10'h000;
  // sequencer states, gray along idle -> start -> wait
  typedef enum logic [1:0]
  {
    ADCPS_IDLE = 2'b00,
    ADCPS_START = 2'b01,
    ADCPS_WAIT = 2'b11
  } adcps_state_t;
endpackage

// ==== src/adcps_top.sv ====
// Implementation choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module adcps_top
(
  // clock and reset
  input wire logic CLOCK_IN,
  input wire logic RSTN_IN,
  // ahb-lite slave
  input wire logic HSEL_IN,
  input wire logic [adcps_pkg::ADCPS_AW-1:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [adcps_pkg::ADCPS_DW-1:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [adcps_pkg::ADCPS_DW-1:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  // standby: high while the converter clock is withheld
  input wire logic CLOCK_STOP_IN,
  // analog core
  output logic [3:0] ANALOG_CHANNEL_OUT,
  output logic ANALOG_START_OUT,
  output logic ANALOG_ABORT_OUT,
  input wire logic ANALOG_DONE_IN,
  input wire logic [adcps_pkg::ADCPS_RW-1:0] ANALOG_RESULT_IN,
  // conversion-done interrupt
  output logic CONV_DONE_IRQ_OUT
);
  import adcps_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////////////
  // registers and wires
  logic [15:0] scan_control_reg0;
  logic [15:0] scan_control_reg1;
  logic [ADCPS_RW-1:0] channel_result_reg [ADCPS_NCH];
  logic active_reg;
  adcps_state_t state_reg;
  adcps_state_t state_next;
  logic [3:0] chan_reg;
  logic [3:0] chan_next;
  logic start_reg;
  logic abort_reg;
  logic irq_reg;
  logic [ADCPS_DW-1:0] rdata_reg;
  logic wr_pend_reg;
  logic [ADCPS_AW-1:0] wr_addr_reg;
  logic wr_c0;
  logic wr_c1;
  logic [15:0] c0_wval;
  logic restart;
  logic kill;
  logic done_ok;
  logic last_ch;
  logic [3:0] first_ch;
  logic [3:0] last_fld;
  logic [3:0] sel_ch;

  // result register index from a byte address; 4'hf means unmapped
  function automatic logic [3:0] res_index(input logic [ADCPS_AW-1:0] a);
    logic [3:0] idx;
    idx = 4'hf;
    if (a >= ADCPS_OFF_RES0 && a <= ADCPS_OFF_RES13 && a[1:0] == 2'b00)
    begin
      idx = 4'((a - ADCPS_OFF_RES0) >> 2);
    end
    return idx;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states, always okay
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT = 1'b0;
  assign HRDATA_OUT = rdata_reg;

  // capture write address phase; data follows next cycle
  always_ff @(posedge CLOCK_IN)
  begin
    if (!RSTN_IN)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
    end
    else
    begin
      wr_pend_reg <= HSEL_IN && HTRANS_IN[1] && HREADY_IN && HWRITE_IN;
      wr_addr_reg <= HADDR_IN;
    end
  end

  assign wr_c0 = wr_pend_reg && (wr_addr_reg == ADCPS_OFF_CTRL0);
  assign wr_c1 = wr_pend_reg && (wr_addr_reg == ADCPS_OFF_CTRL1);
  assign c0_wval = HWDATA_IN[15:0] & ADCPS_C0_WMASK;

  // read data registered at the address phase; unmapped reads zero
  always_ff @(posedge CLOCK_IN)
  begin
    if (!RSTN_IN)
    begin
      rdata_reg <= '0;
    end
    else if (HSEL_IN && HTRANS_IN[1] && HREADY_IN && !HWRITE_IN)
    begin
      if (HADDR_IN == ADCPS_OFF_CTRL0)
      begin
        rdata_reg <= {16'h0000, scan_control_reg0[15], active_reg,
                      scan_control_reg0[13:0]};
      end
      else if (HADDR_IN == ADCPS_OFF_CTRL1)
      begin
        rdata_reg <= {16'h0000, scan_control_reg1};
      end
      else if (res_index(HADDR_IN) != 4'hf)
      begin
        rdata_reg <= {22'h00_0000, channel_result_reg[res_index(HADDR_IN)]};
      end
      else
      begin
        rdata_reg <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // control registers; kept through every standby, cleared by reset, and run also clears when a one-shot pass ends
  always_ff @(posedge CLOCK_IN)
  begin
    if (!RSTN_IN)
    begin
      scan_control_reg0 <= ADCPS_C0_RST;
    end
    else if (wr_c0)
    begin
      scan_control_reg0 <= c0_wval;
    end
    else if (done_ok && last_ch && !scan_control_reg0[ADCPS_C0_POLL])
    begin
      scan_control_reg0[ADCPS_C0_RUN] <= 1'b0; // one-shot trigger mode ends itself
    end
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (!RSTN_IN)
    begin
      scan_control_reg1 <= ADCPS_C1_RST;
    end
    else if (wr_c1)
    begin
      scan_control_reg1 <= HWDATA_IN[15:0];
    end
  end

  // 4-bit channel fields; software keeps first below last
  assign first_ch = scan_control_reg1[ADCPS_C1_FIRST_LSB +: 4];
  assign last_fld = scan_control_reg1[ADCPS_C1_LAST_LSB +: 4];
  assign sel_ch = scan_control_reg1[ADCPS_C1_SEL_LSB +: 4];

  ////////////////////////////////////////////////////////////////////////////////////////
  // sequencer
  // any control write restarts; clearing run only aborts
  assign restart = wr_c0 || wr_c1;
  assign kill = restart && (state_reg != ADCPS_IDLE);
  // a done after abort or while frozen is dropped, so nothing is stored
  assign done_ok = ANALOG_DONE_IN && (state_reg == ADCPS_WAIT) && !restart
                   && !CLOCK_STOP_IN;
  // end of pass: select mode always, scan at last field; illegal order ends too
  assign last_ch = scan_control_reg0[ADCPS_C0_SELMODE] || (chan_reg >= last_fld)
                   || (chan_reg >= 4'(ADCPS_NCH - 1));

  always_comb
  begin
    state_next = state_reg;
    chan_next = chan_reg;
    if (restart)
    begin
      state_next = c0_wval[ADCPS_C0_RUN] || (!wr_c0 && scan_control_reg0[ADCPS_C0_RUN])
                   ? ADCPS_START : ADCPS_IDLE;
      if (wr_c0 ? c0_wval[ADCPS_C0_SELMODE] : scan_control_reg0[ADCPS_C0_SELMODE])
      begin
        chan_next = wr_c1 ? HWDATA_IN[ADCPS_C1_SEL_LSB +: 4] : sel_ch;
      end
      else
      begin
        chan_next = wr_c1 ? HWDATA_IN[ADCPS_C1_FIRST_LSB +: 4] : first_ch;
      end
    end
    else if (!CLOCK_STOP_IN)
    begin
      case (state_reg)
        ADCPS_IDLE:
        begin
          state_next = ADCPS_IDLE;
        end
        ADCPS_START:
        begin
          state_next = ADCPS_WAIT;
        end
        ADCPS_WAIT:
        begin
          if (done_ok)
          begin
            if (!last_ch)
            begin
              chan_next = chan_reg + 4'h1;
              state_next = ADCPS_START;
            end
            else if (scan_control_reg0[ADCPS_C0_POLL])
            begin
              // polling: go round again with no new run write
              chan_next = scan_control_reg0[ADCPS_C0_SELMODE] ? sel_ch : first_ch;
              state_next = ADCPS_START;
            end
            else
            begin
              state_next = ADCPS_IDLE;
            end
          end
        end
        default:
        begin
          state_next = ADCPS_IDLE;
        end
      endcase
    end
  end

  // frozen while the clock is withheld, except that a control write still restarts it
  always_ff @(posedge CLOCK_IN)
  begin
    if (!RSTN_IN)
    begin
      state_reg <= ADCPS_IDLE;
      chan_reg <= 4'h0;
    end
    else
    begin
      state_reg <= state_next;
      chan_reg <= chan_next;
    end
  end

  // active flag follows run, drops when a one-shot pass ends
  always_ff @(posedge CLOCK_IN)
  begin
    if (!RSTN_IN)
    begin
      active_reg <= 1'b0;
    end
    else if (wr_c0)
    begin
      active_reg <= c0_wval[ADCPS_C0_RUN];
    end
    else if (done_ok && last_ch && !scan_control_reg0[ADCPS_C0_POLL])
    begin
      active_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // analog core strobes; start held back while the clock is withheld
  always_ff @(posedge CLOCK_IN)
  begin
    if (!RSTN_IN)
    begin
      start_reg <= 1'b0;
      abort_reg <= 1'b0;
    end
    else
    begin
      start_reg <= (state_reg == ADCPS_START) && !restart && !CLOCK_STOP_IN;
      abort_reg <= kill;
    end
  end

  assign ANALOG_START_OUT = start_reg;
  assign ANALOG_ABORT_OUT = abort_reg;
  assign ANALOG_CHANNEL_OUT = chan_reg;

  // one irq per conversion in select mode, per pass in scan mode
  always_ff @(posedge CLOCK_IN)
  begin
    if (!RSTN_IN)
    begin
      irq_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= done_ok && last_ch;
    end
  end

  assign CONV_DONE_IRQ_OUT = irq_reg;

  ////////////////////////////////////////////////////////////////////////////////////////
  // result registers, one per input, plainly overwritten
  genvar g;
  generate
    for (g = 0; g < ADCPS_NCH; g++)
    begin : g_res
      always_ff @(posedge CLOCK_IN)
      begin
        if (!RSTN_IN)
        begin
          channel_result_reg[g] <= ADCPS_RES_RST;
        end
        else if (done_ok && chan_reg == 4'(g))
        begin
          channel_result_reg[g] <= ANALOG_RESULT_IN;
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ==== test/adcps_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module adcps_asserts
(
  // clock and reset
  input wire logic CLOCK_IN,
  input wire logic RSTN_IN,
  // standby and analog link
  input wire logic CLOCK_STOP_IN,
  input wire logic [3:0] ANALOG_CHANNEL_OUT,
  input wire logic ANALOG_START_OUT,
  input wire logic ANALOG_ABORT_OUT,
  input wire logic ANALOG_DONE_IN,
  input wire logic CONV_DONE_IRQ_OUT
);
  // one clock domain, so clock and reset are given once
  default clocking @(posedge CLOCK_IN);
  endclocking
  default disable iff (!RSTN_IN);
  ////////////////////////////////
  AST_START_PULSE:
    assert property (ANALOG_START_OUT |=> !ANALOG_START_OUT) else $error("start too long");
  AST_ABORT_PULSE:
    assert property (ANALOG_ABORT_OUT |=> !ANALOG_ABORT_OUT) else $error("abort too long");
  AST_IRQ_PULSE:
    assert property (CONV_DONE_IRQ_OUT |=> !CONV_DONE_IRQ_OUT) else $error("irq too long");
  AST_IRQ_CAUSE:
    assert property (CONV_DONE_IRQ_OUT |-> $past(ANALOG_DONE_IN)) else $error("irq no done");
  AST_CHAN_RANGE:
    assert property (ANALOG_START_OUT |-> ANALOG_CHANNEL_OUT <= 4'hD) else $error("bad channel");
  // abort excused: a control write may move the channel
  AST_CHAN_HELD:
    assert property ($past(ANALOG_START_OUT) && !ANALOG_ABORT_OUT |-> $stable(ANALOG_CHANNEL_OUT))
      else $error("channel moved");
  AST_STOP_NO_START:
    assert property (CLOCK_STOP_IN [*3] |-> !ANALOG_START_OUT) else $error("start in standby");
  AST_STOP_NO_IRQ:
    assert property (CLOCK_STOP_IN [*2] |=> !CONV_DONE_IRQ_OUT) else $error("irq in standby");
endmodule
bind adcps_top adcps_asserts adcps_asserts_i (.CLOCK_IN, .RSTN_IN, .CLOCK_STOP_IN,
  .ANALOG_CHANNEL_OUT, .ANALOG_START_OUT, .ANALOG_ABORT_OUT, .ANALOG_DONE_IN,
  .CONV_DONE_IRQ_OUT);
`default_nettype wire

// ==== test/adcps_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module adcps_core_model
(
  // clock, standby and knobs
  input wire logic clk_in,
  input wire logic stop_in,
  input wire logic [3:0] delay_in,
  input wire logic [9:0] value_in,
  // link to the sequencer
  input wire logic start_in,
  input wire logic abort_in,
  output logic done_out,
  output logic [9:0] result_out
);
  logic [3:0] cnt_reg = 4'h0;
  initial done_out = 1'b0;
  initial result_out = 10'h155;
  // one conversion at a time; the result line toggles outside done
  // so a stale value is never mistaken for a fresh one
  always @(posedge clk_in)
  begin
    if (!stop_in)
    begin
      done_out <= 1'b0;
      result_out <= ~result_out;
      if (abort_in)
        cnt_reg <= 4'h0;
      else if (start_in)
        cnt_reg <= delay_in;
      else if (cnt_reg == 4'h1)
      begin
        cnt_reg <= 4'h0;
        done_out <= 1'b1;
        result_out <= value_in;
      end
      else if (cnt_reg != 4'h0)
        cnt_reg <= cnt_reg - 4'h1;
    end
  end
endmodule
`default_nettype wire

// ==== test/adcps_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module adcps_tb_top;
  import adcps_pkg::*;
  logic clk = '0, rstn = '0, hsel = '0, hwrite = '0, stop = '0, hready, done, start, abort, irq;
  logic [1:0] htrans = '0;
  logic [7:0] haddr = '0;
  logic [31:0] hwdata = '0, hrdata, rd;
  logic [3:0] chan, dly = 4'h4;
  logic [9:0] val = '0, res;
  logic [9:0] exp_res [14] = '{default: 10'h000};
  int fails = 0, n_checks = 0, seed = 25184, irqs = 0;
  int sel = 0, first = 0, last = 0, scan = 0, running = 0, cur = 0, exp_ch = 0;
  logic irq_due = '0;
  logic hresp;
  always #2 clk = ~clk;
  always @(posedge clk) val <= 10'($random(seed));
  adcps_top adcps_top_i (.CLOCK_IN(clk), .RSTN_IN(rstn), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
    .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .CLOCK_STOP_IN(stop), .ANALOG_CHANNEL_OUT(chan), .ANALOG_START_OUT(start),
    .ANALOG_ABORT_OUT(abort), .ANALOG_DONE_IN(done), .ANALOG_RESULT_IN(res),
    .CONV_DONE_IRQ_OUT(irq));
  adcps_core_model adcps_core_model_i (.clk_in(clk), .stop_in(stop), .delay_in(dly),
    .value_in(val), .start_in(start), .abort_in(abort), .done_out(done), .result_out(res));
  ////////////////////////////////
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
  begin
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  // single word transfer; the bench model follows each control write
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
  begin
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    cmp(32'(hresp), 32'h0000_0000);
    if (w && a == ADCPS_OFF_CTRL1)
    begin
      first = d[3:0];
      last = d[7:4];
      sel = d[11:8];
    end
    if (w && a == ADCPS_OFF_CTRL0)
    begin
      running = d[ADCPS_C0_RUN];
      scan = !d[ADCPS_C0_SELMODE];
    end
    if (w)
      exp_ch = scan ? first : sel;
  end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
  begin
    bus(a, 1'b0, 32'h0000_0000);
    cmp(rd, e);
  end
  endtask
  task automatic wait_irq(input int n);
  begin
    int t = irqs + n;
    while (irqs < t) @(posedge clk);
  end
  endtask
  // writes are launched just after a start so no done can meet them
  task automatic wait_start();
  begin
    do @(posedge clk); while (start !== 1'b1);
  end
  endtask
  task automatic run(input logic [31:0] c1, input logic [31:0] c0, input int n, input int mid);
  begin
    dly <= 4'h4 + 4'($unsigned($random(seed)) % 8);
    bus(ADCPS_OFF_CTRL1, 1'b1, c1);
    bus(ADCPS_OFF_CTRL0, 1'b1, c0);
    wait_irq(n);
    rchk(ADCPS_OFF_CTRL0, c0 | 32'h0000_4000);
    wait_start();
    // a busy control write must drop the running conversion at once
    if (mid == 1)
    begin
      bus(ADCPS_OFF_CTRL1, 1'b1, 32'h0000_0031);
      @(posedge clk);
      cmp(32'(abort), 32'h0000_0001);
    end
    if (mid == 2)
      stop <= 1'b1;
    repeat (30 * mid) @(posedge clk);
    stop <= 1'b0;
    wait_irq(2);
    wait_start();
    bus(ADCPS_OFF_CTRL0, 1'b1, c0 & 32'h0000_7FFF);
    @(posedge clk);
    cmp(32'(abort), 32'h0000_0001);
    rchk(ADCPS_OFF_CTRL0, c0 & 32'h0000_3FFF);
    repeat (40) @(posedge clk);
    for (int m = 0; m < 14; m++)
      rchk(ADCPS_OFF_RES0 + 8'(4 * m), 32'(exp_res[m]));
  end
  endtask
  task automatic wrap_up();
  begin
    if (fails == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  ////////////////////////////////
  // bench model: expected channel order, stored results and irq timing
  always @(posedge clk)
  begin
    if (rstn)
    begin
      cmp(irq, irq_due);
      irq_due = 1'b0;
      if (irq)
        irqs++;
      if (start)
      begin
        cmp(running, 1);
        cmp(chan, exp_ch);
        cur = chan;
      end
      if (done && !stop)
      begin
        exp_res[cur] = res;
        irq_due = !scan || cur == last;
        exp_ch = !scan ? sel : (cur == last ? first : cur + 1);
      end
    end
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rchk(ADCPS_OFF_CTRL1, 0);
    rchk(8'h80, 0);
    // every scan below keeps first under last, or both at zero
    run(32'h0000_0D00, 32'h0000_8C00, 3, 0);
    run(32'h0000_0052, 32'h0000_8400, 2, 0);
    run(32'h0000_0000, 32'h0000_8400, 3, 0);
    run(32'h0000_00D0, 32'h0000_8400, 1, 0);
    run(32'h0000_0063, 32'h0000_8400, 1, 1);
    run(32'h0000_0300, 32'h0000_8C00, 2, 2);
    wrap_up();
  end
  // cuts a hang well past the longest expected run
  initial
  begin
    #200000;
    fails++;
    wrap_up();
  end
endmodule
`default_nettype wire
